// [logic/iso14443a_response_coder.sv]
// Contract
// - REQA or WUPA answered with sixteen-bit ATQA.
// - ATQA reserved, proprietary and b6 bits zero.
// - ATQA b8 zero, b7 one: double UID.
// - ATQA anticollision field is 00100.
// - Cascade level 1 SAK is 04h.
// - Level 2 SAK 20h when non-compliance clear.
// - Level 2 SAK 00h when non-compliance set.
// - Level 2 SAK 40h when passive target set.
// - RATS answered with five ATS bytes, ordered.
// - ATS length byte is always five.
// - Format byte b8 zero, b7..b5 one.
// - Format low nibble copies frame-size config.
// - Bit-rate byte built from rate configuration.
// - Bit-rate b8 from same-rate configuration.
// - Timing byte: wait config high, zero low.
// - Protocol-option byte is 02h.
// - Proprietary frame: PCB, optional CID, INF, CRC.
// - Replies reuse the incoming prolog layout.
// - PCB b4 set means CID byte follows.
// - Wake-Up reply echoes INF byte 01h.
// - Accepted Wake-Up raises wake-up interrupt.
// - CID mismatch on own command: ignore silently.
// - Active-state interrupt after level 2 SAK.
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module iso14443a_response_coder (
	input  wire logic                         core_clk,
	input  wire logic                         reset_n,
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic [31:0]                  hwdata,
	input  wire logic                         hready,
	output logic                              hreadyout,
	output logic                              hresp,
	output logic [31:0]                       hrdata,
	input  wire logic                         atqa_req,
	input  wire logic                         sel_cl1_req,
	input  wire logic                         sel_cl2_req,
	input  wire logic                         rx_valid,
	input  wire response_coder_pkg::rx_byte_t rx_byte,
	output logic                              tx_valid,
	output logic [7:0]                        tx_data,
	output logic                              tx_last,
	input  wire logic                         tx_ready,
	output logic                              wakeup_irq,
	output logic                              active_irq
);

	// ************************************************************
	// Bus slave.
	// ************************************************************
	response_coder_pkg::cfg_t cfg_reg;
	logic [3:0]               cid_reg;
	logic                     wr_pend_reg;
	logic [7:0]               wr_addr_reg;
	logic [31:0]              hrdata_reg;
	logic [31:0]              status_word;
	logic [31:0]              rd_word;
	wire                      addr_ph = hsel & hready & htrans[1];
	wire                      hit_cfg = wr_addr_reg ==
	                                    response_coder_pkg::ADDR_CFG;
	wire                      hit_cid = wr_addr_reg ==
	                                    response_coder_pkg::ADDR_CID;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	assign rd_word =
		(haddr[7:0] == response_coder_pkg::ADDR_CFG)    ? cfg_reg :
		(haddr[7:0] == response_coder_pkg::ADDR_CID)    ? {28'h0, cid_reg} :
		(haddr[7:0] == response_coder_pkg::ADDR_STATUS) ? status_word :
		32'h0000_0000;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_reg  <= 32'h0000_0000;
		end else begin
			wr_pend_reg <= addr_ph & hwrite;
			if (addr_ph) begin
				wr_addr_reg <= haddr[7:0];
				hrdata_reg  <= hwrite ? 32'h0000_0000 : rd_word;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_reg <= response_coder_pkg::CFG_RESET;
			cid_reg <= response_coder_pkg::CID_RESET;
		end else if (wr_pend_reg) begin
			if (hit_cfg) begin
				cfg_reg     <= hwdata;
				cfg_reg.pad <= 14'h0000;
			end
			if (hit_cid) begin
				cid_reg <= hwdata[3:0];
			end
		end
	end

	// ************************************************************
	// Reply builders.
	// ************************************************************
	response_coder_pkg::state_t state_reg;
	response_coder_pkg::state_t state_next;
	logic [7:0]                 tx_buf_reg [0:4];
	logic [7:0]                 load_buf   [0:4];
	logic [2:0]                 tx_cnt_reg;
	logic [2:0]                 load_cnt;
	logic                       load_en;
	logic                       sak2_pend_reg;
	logic                       active_reg;
	logic                       rats_ok_reg;
	logic [7:0]                 pcb_reg;
	logic [7:0]                 cid_byte_reg;
	logic                       cid_in_reg;
	logic [7:0]                 sak2;
	logic [7:0]                 ats_t0;
	logic [7:0]                 ats_ta;
	logic [7:0]                 ats_tb;

	wire idle     = state_reg == response_coder_pkg::ST_IDLE;
	wire rx_take  = rx_valid & ~atqa_req & ~sel_cl1_req & ~sel_cl2_req;
	wire prop_pcb = (rx_byte.data & response_coder_pkg::PROP_MASK) ==
	                response_coder_pkg::PROP_PCB;
	wire cid_ok   = rx_byte.data[3:0] == cid_reg;
	wire tx_fire  = tx_valid & tx_ready;
	wire tx_done  = tx_fire & tx_last;
	wire rats_go  = state_reg == response_coder_pkg::ST_RATS &
	                rx_valid & rx_byte.last;
	wire wake_go  = state_reg == response_coder_pkg::ST_PROP_INF &
	                rx_valid & rx_byte.last &
	                rx_byte.data == response_coder_pkg::WAKE_INF;

	// Passive target wins outright over the other level 2 choices.
	assign sak2 = cfg_reg.passive_target_cfg ?
	              response_coder_pkg::SAK_CL2_PASSIVE :
	              cfg_reg.l4_noncompliant_cfg ?
	              response_coder_pkg::SAK_CL2_NONE :
	              response_coder_pkg::SAK_CL2_L4;
	assign ats_t0 = {response_coder_pkg::ATS_T0_HI, cfg_reg.fsci};
	assign ats_ta = {cfg_reg.same_rate_cfg,
	                 cfg_reg.tag_to_reader_848_cfg,
	                 cfg_reg.tag_to_reader_424_cfg,
	                 cfg_reg.tag_to_reader_212_cfg, 1'b0,
	                 cfg_reg.reader_to_tag_848_cfg,
	                 cfg_reg.reader_to_tag_424_cfg,
	                 cfg_reg.reader_to_tag_212_cfg};
	assign ats_tb = {cfg_reg.fwi, response_coder_pkg::ATS_SFGI};

	always_comb begin
		load_en  = 1'b0;
		load_cnt = 3'h0;
		for (int i = 0; i < response_coder_pkg::TX_DEPTH; i++) begin
			load_buf[i] = 8'h00;
		end
		if (idle && atqa_req) begin
			load_en     = 1'b1;
			load_cnt    = response_coder_pkg::LEN_ATQA;
			load_buf[0] = response_coder_pkg::ATQA_LO;
			load_buf[1] = response_coder_pkg::ATQA_HI;
		end else if (idle && sel_cl1_req) begin
			load_en     = 1'b1;
			load_cnt    = response_coder_pkg::LEN_SAK;
			load_buf[0] = response_coder_pkg::SAK_CL1;
		end else if (idle && sel_cl2_req) begin
			load_en     = 1'b1;
			load_cnt    = response_coder_pkg::LEN_SAK;
			load_buf[0] = sak2;
		end else if (rats_go) begin
			load_en     = 1'b1;
			load_cnt    = response_coder_pkg::LEN_ATS;
			load_buf[0] = response_coder_pkg::ATS_TL;
			load_buf[1] = ats_t0;
			load_buf[2] = ats_ta;
			load_buf[3] = ats_tb;
			load_buf[4] = response_coder_pkg::ATS_TC;
		end else if (wake_go) begin
			load_en     = 1'b1;
			load_buf[0] = pcb_reg;
			if (cid_in_reg) begin
				load_cnt    = 3'h3;
				load_buf[1] = cid_byte_reg;
				load_buf[2] = response_coder_pkg::WAKE_INF;
			end else begin
				load_cnt    = 3'h2;
				load_buf[1] = response_coder_pkg::WAKE_INF;
			end
		end
	end

	// ************************************************************
	// Frame parser and reply sequencer.
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
		response_coder_pkg::ST_IDLE: begin
			if (load_en) begin
				state_next = response_coder_pkg::ST_TX;
			end else if (rx_take && rx_byte.first && !rx_byte.last) begin
				if (rx_byte.data == response_coder_pkg::RATS_CMD &&
				    rats_ok_reg) begin
					state_next = response_coder_pkg::ST_RATS;
				end else if (prop_pcb) begin
					state_next = rx_byte.data[response_coder_pkg::PCB_CID_BIT] ?
					             response_coder_pkg::ST_PROP_CID :
					             response_coder_pkg::ST_PROP_INF;
				end else begin
					state_next = response_coder_pkg::ST_DROP;
				end
			end
		end
		response_coder_pkg::ST_PROP_CID: begin
			if (rx_valid) begin
				state_next = rx_byte.last ? response_coder_pkg::ST_IDLE :
				             cid_ok ? response_coder_pkg::ST_PROP_INF :
				             response_coder_pkg::ST_DROP;
			end
		end
		response_coder_pkg::ST_PROP_INF: begin
			if (load_en) begin
				state_next = response_coder_pkg::ST_TX;
			end else if (rx_valid) begin
				state_next = rx_byte.last ? response_coder_pkg::ST_IDLE :
				             response_coder_pkg::ST_DROP;
			end
		end
		response_coder_pkg::ST_RATS: begin
			if (load_en) begin
				state_next = response_coder_pkg::ST_TX;
			end else if (rx_valid) begin
				state_next = response_coder_pkg::ST_DROP;
			end
		end
		response_coder_pkg::ST_DROP: begin
			if (rx_valid && rx_byte.last) begin
				state_next = response_coder_pkg::ST_IDLE;
			end
		end
		response_coder_pkg::ST_TX: begin
			if (tx_done) begin
				state_next = response_coder_pkg::ST_IDLE;
			end
		end
		default: begin
			state_next = response_coder_pkg::ST_IDLE;
		end
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg    <= response_coder_pkg::ST_IDLE;
			tx_cnt_reg   <= 3'h0;
			pcb_reg      <= 8'h00;
			cid_byte_reg <= 8'h00;
			cid_in_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (load_en) begin
				tx_cnt_reg <= load_cnt;
			end else if (tx_fire) begin
				tx_cnt_reg <= tx_cnt_reg - 3'h1;
			end
			if (idle && rx_take && rx_byte.first) begin
				pcb_reg    <= rx_byte.data;
				cid_in_reg <= rx_byte.data[response_coder_pkg::PCB_CID_BIT];
			end
			if (state_reg == response_coder_pkg::ST_PROP_CID && rx_valid) begin
				cid_byte_reg <= rx_byte.data;
			end
		end
	end

	// Each reply slot loads in parallel and shifts toward slot 0.
	for (genvar g = 0; g < response_coder_pkg::TX_DEPTH; g++) begin : g_slot
		always_ff @(posedge core_clk or negedge reset_n) begin
			if (!reset_n) begin
				tx_buf_reg[g] <= 8'h00;
			end else if (load_en) begin
				tx_buf_reg[g] <= load_buf[g];
			end else if (tx_fire) begin
				tx_buf_reg[g] <= (g == response_coder_pkg::TX_DEPTH - 1) ?
				                 8'h00 : tx_buf_reg[(g + 1) %
				                 response_coder_pkg::TX_DEPTH];
			end
		end
	end

	assign tx_valid = state_reg == response_coder_pkg::ST_TX;
	assign tx_data  = tx_buf_reg[0];
	assign tx_last  = tx_cnt_reg == 3'h1;

	// ************************************************************
	// Protocol state and event pulses.
	// ************************************************************
	logic wake_irq_reg;
	logic act_irq_reg;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sak2_pend_reg <= 1'b0;
			active_reg    <= 1'b0;
			rats_ok_reg   <= 1'b0;
			wake_irq_reg  <= 1'b0;
			act_irq_reg   <= 1'b0;
		end else begin
			wake_irq_reg <= wake_go;
			act_irq_reg  <= tx_done & sak2_pend_reg &
			                cfg_reg.active_state_irq_cfg;
			if (idle && load_en) begin
				sak2_pend_reg <= sel_cl2_req & ~atqa_req & ~sel_cl1_req;
			end
			if (idle && (atqa_req || sel_cl1_req)) begin
				active_reg  <= 1'b0;
				rats_ok_reg <= 1'b0;
			end else if (tx_done && sak2_pend_reg) begin
				active_reg  <= 1'b1;
				rats_ok_reg <= 1'b1;
				sak2_pend_reg <= 1'b0;
			end else if (rats_go) begin
				rats_ok_reg <= 1'b0;
			end
		end
	end

	assign wakeup_irq  = wake_irq_reg;
	assign active_irq  = act_irq_reg;
	assign status_word = {25'h0, state_reg, sak2_pend_reg, rats_ok_reg,
	                      active_reg, tx_valid};

	// ************************************************************
	// Checks.
	// ************************************************************
	sequence seq_wake_frame;
		idle && rx_take && rx_byte.first && !rx_byte.last && prop_pcb &&
		!rx_byte.data[response_coder_pkg::PCB_CID_BIT]
		##1 rx_valid && rx_byte.last &&
		rx_byte.data == response_coder_pkg::WAKE_INF;
	endsequence

	AST_ATQA: assert property (@(posedge core_clk) disable iff (!reset_n)
		idle && atqa_req |=> tx_valid && tx_data == 8'h44 && !tx_last)
		else $error("ATQA first byte wrong.");
	AST_ATQA_HI: assert property (@(posedge core_clk) disable iff (!reset_n)
		idle && atqa_req ##1 tx_ready |=> tx_data == 8'h00 && tx_last)
		else $error("ATQA second byte wrong.");
	AST_SAK1: assert property (@(posedge core_clk) disable iff (!reset_n)
		idle && !atqa_req && sel_cl1_req |=> tx_data == 8'h04 && tx_last)
		else $error("Level 1 SAK wrong.");
	AST_SAK2: assert property (@(posedge core_clk) disable iff (!reset_n)
		idle && !atqa_req && !sel_cl1_req && sel_cl2_req |=>
		tx_data == ($past(cfg_reg.passive_target_cfg) ? 8'h40 :
		$past(cfg_reg.l4_noncompliant_cfg) ? 8'h00 : 8'h20))
		else $error("Level 2 SAK wrong.");
	AST_ATS_LEN: assert property (@(posedge core_clk) disable iff (!reset_n)
		rats_go |=> tx_data == 8'h05 && tx_cnt_reg == 3'h5)
		else $error("ATS length byte wrong.");
	AST_ATS_T0: assert property (@(posedge core_clk) disable iff (!reset_n)
		rats_go ##1 tx_ready |=> tx_data[7:4] == 4'h7 &&
		tx_data[3:0] == cfg_reg.fsci)
		else $error("ATS format byte wrong.");
	AST_WAKE_IRQ: assert property (@(posedge core_clk) disable iff (!reset_n)
		seq_wake_frame |=> wakeup_irq ##1 !wakeup_irq)
		else $error("Wake-up pulse missing.");
	AST_WAKE_ECHO: assert property (@(posedge core_clk) disable iff (!reset_n)
		seq_wake_frame ##1 tx_ready |=> tx_data == 8'h01 && tx_last)
		else $error("Wake-up echo wrong.");
	AST_CID_MISS: assert property (@(posedge core_clk) disable iff (!reset_n)
		state_reg == response_coder_pkg::ST_PROP_CID && rx_valid &&
		!rx_byte.last && !cid_ok |=> !tx_valid [*2])
		else $error("Reply after CID mismatch.");
	AST_ACT_IRQ: assert property (@(posedge core_clk) disable iff (!reset_n)
		active_irq |-> $past(tx_done) && $past(cfg_reg.active_state_irq_cfg)
		&& active_reg)
		else $error("Active pulse without level 2 SAK.");

endmodule
`default_nettype wire

// [logic/response_coder_pkg.sv]
`default_nettype none
package response_coder_pkg;

	// ************************************************************
	// Register map and reset values.
	// ************************************************************
	localparam logic [7:0]  ADDR_CFG    = 8'h00;
	localparam logic [7:0]  ADDR_CID    = 8'h04;
	localparam logic [7:0]  ADDR_STATUS = 8'h08;
	localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
	localparam logic [3:0]  CID_RESET   = 4'h0;

	// ************************************************************
	// Reply codes and frame fields.
	// ************************************************************
	localparam logic [7:0] ATQA_LO         = 8'h44;
	localparam logic [7:0] ATQA_HI         = 8'h00;
	localparam logic [7:0] SAK_CL1         = 8'h04;
	localparam logic [7:0] SAK_CL2_L4      = 8'h20;
	localparam logic [7:0] SAK_CL2_NONE    = 8'h00;
	localparam logic [7:0] SAK_CL2_PASSIVE = 8'h40;
	localparam logic [7:0] ATS_TL          = 8'h05;
	localparam logic [3:0] ATS_T0_HI       = 4'h7;
	localparam logic [3:0] ATS_SFGI        = 4'h0;
	localparam logic [7:0] ATS_TC          = 8'h02;
	localparam logic [7:0] RATS_CMD        = 8'hE0;
	localparam logic [7:0] PROP_MASK       = 8'hF7;
	localparam logic [7:0] PROP_PCB        = 8'h65;
	localparam int         PCB_CID_BIT     = 3;
	localparam logic [7:0] WAKE_INF        = 8'h01;
	localparam int         TX_DEPTH        = 5;
	localparam logic [2:0] LEN_ATQA        = 3'h2;
	localparam logic [2:0] LEN_SAK         = 3'h1;
	localparam logic [2:0] LEN_ATS         = 3'h5;

	// ************************************************************
	// Carried types.
	// ************************************************************
	typedef struct packed {
		logic [13:0] pad;
		logic        active_state_irq_cfg;
		logic        l4_noncompliant_cfg;
		logic        passive_target_cfg;
		logic        same_rate_cfg;
		logic        tag_to_reader_848_cfg;
		logic        tag_to_reader_424_cfg;
		logic        tag_to_reader_212_cfg;
		logic        reader_to_tag_848_cfg;
		logic        reader_to_tag_424_cfg;
		logic        reader_to_tag_212_cfg;
		logic [3:0]  fwi;
		logic [3:0]  fsci;
	} cfg_t;

	typedef struct packed {
		logic       first;
		logic       last;
		logic [7:0] data;
	} rx_byte_t;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_PROP_CID = 3'b001,
		ST_PROP_INF = 3'b010,
		ST_RATS     = 3'b011,
		ST_DROP     = 3'b100,
		ST_TX       = 3'b101
	} state_t;

endpackage
`default_nettype wire

// [tb/pcd_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pcd_model (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic       slow,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last,
	output logic            tx_ready
);
	// ****************************************
	// Reader side: takes reply bytes, may stall.
	// ****************************************
	logic [8:0] got_q[$];

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_ready <= 1'b0;
		end else begin
			tx_ready <= slow ? ~tx_ready : 1'b1;
			if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
				got_q.push_back({tx_last, tx_data});
			end
		end
	end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                         core_clk;
	logic                         reset_n;
	logic                         hsel;
	logic [31:0]                  haddr;
	logic [1:0]                   htrans;
	logic                         hwrite;
	logic [2:0]                   hsize;
	logic [31:0]                  hwdata;
	logic                         hreadyout;
	logic                         hresp;
	logic [31:0]                  hrdata;
	logic [2:0]                   pls;
	logic                         rx_valid;
	response_coder_pkg::rx_byte_t rx_byte;
	logic                         tx_valid;
	logic [7:0]                   tx_data;
	logic                         tx_last;
	logic                         tx_ready;
	logic                         wakeup_irq;
	logic                         active_irq;
	logic                         slow;
	logic [31:0]                  seed;
	logic [31:0]                  cfg;
	logic [31:0]                  rd;
	logic [8:0]                   exp_q[$];
	int                           n_fail;
	int                           num_checks;
	int                           n_act;
	int                           n_wake;
	int                           a0;

	iso14443a_response_coder u_dut (
		.core_clk   (core_clk),
		.reset_n    (reset_n),
		.hsel       (hsel),
		.haddr      (haddr),
		.htrans     (htrans),
		.hwrite     (hwrite),
		.hsize      (hsize),
		.hwdata     (hwdata),
		.hready     (hreadyout),
		.hreadyout  (hreadyout),
		.hresp      (hresp),
		.hrdata     (hrdata),
		.atqa_req   (pls[2]),
		.sel_cl1_req(pls[1]),
		.sel_cl2_req(pls[0]),
		.rx_valid   (rx_valid),
		.rx_byte    (rx_byte),
		.tx_valid   (tx_valid),
		.tx_data    (tx_data),
		.tx_last    (tx_last),
		.tx_ready   (tx_ready),
		.wakeup_irq (wakeup_irq),
		.active_irq (active_irq)
	);

	pcd_model u_pcd (
		.core_clk(core_clk),
		.reset_n (reset_n),
		.slow    (slow),
		.tx_valid(tx_valid),
		.tx_data (tx_data),
		.tx_last (tx_last),
		.tx_ready(tx_ready)
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (active_irq === 1'b1) n_act++;
		if (wakeup_irq === 1'b1) n_wake++;
	end

	// ****************************************
	// Expected values and checks.
	// ****************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	function automatic logic [7:0] sak2(input logic [31:0] c);
		return c[15] ? 8'h40 : (c[16] ? 8'h00 : 8'h20);
	endfunction

	function automatic logic [7:0] ats(input int k, input logic [31:0] c);
		case (k)
			0: return 8'h05;
			1: return {1'b0, 3'b111, c[3:0]};
			2: return {c[14:11], 1'b0, c[10:8]};
			3: return {c[7:4], 4'h0};
			default: return 8'h02;
		endcase
	endfunction

	task automatic chk_byte(input string nm, input logic [8:0] e,
		input logic [8:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_word(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_count(input string nm, input int e, input int g);
		num_checks++;
		if (g != e) begin
			n_fail++;
			$display("MISMATCH %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	task automatic summarize();
		if (n_fail == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ****************************************
	// Drivers.
	// ****************************************
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk_word("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic pulse(input logic [2:0] m);
		@(posedge core_clk);
		pls <= m;
		@(posedge core_clk);
		pls <= 3'b000;
	endtask

	task automatic send(input logic [7:0] b[$]);
		for (int i = 0; i < b.size(); i++) begin
			@(posedge core_clk);
			rx_valid <= 1'b1;
			rx_byte <= {i == 0, i == b.size() - 1, b[i]};
		end
		@(posedge core_clk);
		rx_valid <= 1'b0;
		rx_byte <= {2'b00, ~b[b.size() - 1]};
	endtask

	task automatic take();
		int w;
		w = 0;
		while (u_pcd.got_q.size() < exp_q.size() && w < 300) begin
			@(posedge core_clk);
			w++;
		end
		repeat (12) @(posedge core_clk);
		chk_count("reply length", exp_q.size(), u_pcd.got_q.size());
		for (int i = 0; i < exp_q.size() && i < u_pcd.got_q.size(); i++)
			chk_byte("reply byte", exp_q[i], u_pcd.got_q[i]);
		exp_q.delete();
		u_pcd.got_q.delete();
	endtask

	initial begin
		repeat (30000) @(posedge core_clk);
		n_fail++;
		summarize();
	end

	initial begin
		reset_n = 1'b0;
		{hsel, hwrite, rx_valid, slow} = 4'h0;
		haddr = 32'h0;
		htrans = 2'b00;
		hsize = 3'b010;
		hwdata = 32'h0;
		pls = 3'b000;
		rx_byte = '0;
		seed = 32'hB852;
		n_fail = 0;
		num_checks = 0;
		n_act = 0;
		n_wake = 0;
		repeat (10) @(posedge core_clk);
		reset_n <= 1'b1;
		bus(response_coder_pkg::ADDR_CFG, 1'b0, 32'h0);
		chk_word("cfg reset", response_coder_pkg::CFG_RESET, rd);
		bus(8'h0C, 1'b0, 32'h0);
		chk_word("unmapped", 32'h0, rd);
		bus(response_coder_pkg::ADDR_CID, 1'b1, 32'hFFFF_FFFA);
		bus(response_coder_pkg::ADDR_CID, 1'b0, 32'h0);
		chk_word("cid", 32'h0000_000A, rd);
		slow <= 1'b1;
		pulse(3'b100);
		pulse(3'b010);
		exp_q = '{9'h044, 9'h100};
		take();
		slow <= 1'b0;
		pulse(3'b010);
		exp_q = '{9'h104};
		take();
		pulse(3'b011);
		exp_q = '{9'h104};
		take();
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			cfg = {14'h0, seed[17], i[1:0], seed[14:0]};
			slow <= i[2];
			bus(response_coder_pkg::ADDR_CFG, 1'b1, {seed[31:18], cfg[17:0]});
			bus(response_coder_pkg::ADDR_CFG, 1'b0, 32'h0);
			chk_word("cfg", cfg, rd);
			a0 = n_act;
			pulse(3'b001);
			exp_q = '{{1'b1, sak2(cfg)}};
			take();
			chk_count("active irq", int'(cfg[17]), n_act - a0);
			bus(response_coder_pkg::ADDR_STATUS, 1'b0, 32'h0);
			chk_word("status", 32'h0000_0006, rd);
			send('{8'hE0, 8'h50});
			for (int k = 0; k < 5; k++) exp_q.push_back({k == 4, ats(k, cfg)});
			take();
			send('{8'hE0, 8'h50});
			take();
			a0 = n_wake;
			send('{8'h65, 8'h01});
			exp_q = '{9'h065, 9'h101};
			take();
			send('{8'h6D, 8'h0A, 8'h01});
			exp_q = '{9'h06D, 9'h00A, 9'h101};
			take();
			send('{8'h6D, 8'h0B, 8'h01});
			take();
			send('{8'h67, 8'h01});
			take();
			chk_count("wake irq", 2, n_wake - a0);
		end
		summarize();
	end
endmodule
`default_nettype wire
